/* File: sim/nrc_host.sv */
`timescale 1ns/1ps
// Host model: issues one single word transfer at a time on the register bus.
module nrc_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // The bus is idle at time zero.
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    // Each phase is held until hready is sampled high; read data is taken at that edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // A released data line flips, so a stale word is never taken for a fresh one.
        hwdata <= ~hwdata;
    endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench
    import nrc_pkg::*;
;
    localparam logic [63:0] K1 = 64'h0123456789ABCDEF;
    localparam logic [63:0] K2 = 64'hFEDCBA9876543210;
    localparam logic [63:0] K3 = 64'h5A5A0000A5A5FFFF;
    logic hclk = 1'b0;
    logic hresetn;
    logic hsel, hwrite, hreadyout, hresp, cmd_done, cmd_conflict;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ctrl_reset_pin, power_loss_pin;
    int failures = 0;
    int n_checks = 0;

    // A 100 ns clock.
    always #50 hclk = ~hclk;

    nrc_host i_nrc_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    nrc_checker i_nrc_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ctrl_reset_pin(ctrl_reset_pin),
        .power_loss_pin(power_loss_pin), .cmd_done(cmd_done), .cmd_conflict(cmd_conflict));

    // Prints the verdict once and ends the run.
    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Compare helpers for single flags and whole words.
    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_nrc_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        i_nrc_host.xfer(1'b0, a, 32'h00000000, q);
    endtask

    // Check outcome is one cycle after the command word lands; both flags are pulses.
    task automatic cmd(input nrc_cmd_s c, input logic exp);
        wr(OFF_CMD, c);
        @(posedge hclk);
        #1;
        chk_bit(cmd_done, 1'b1, "done missing");
        chk_bit(cmd_conflict, exp, "conflict flag");
    endtask

    task automatic op(input nrc_class_e cl, input logic [1:0] h, input logic ns,
                      input nrc_rtype_e rt, input logic [1:0] hd, input logic exp);
        nrc_cmd_s c;
        c = '0;
        c.cls = cl;
        c.host = h;
        c.nsid = ns;
        c.rtype = rt;
        c.holder = hd;
        cmd(c, exp);
    endtask

    // Keys go in first, low and high words, then the register command itself.
    task automatic reg_op(input logic [1:0] h, input logic ns, input logic [2:0] act,
                          input logic iek, input logic [1:0] pt, input logic [63:0] cur,
                          input logic [63:0] nw, input logic exp);
        nrc_cmd_s c;
        wr(OFF_CUR_KEY_LO, cur[31:0]);
        wr(OFF_CUR_KEY_HI, cur[63:32]);
        wr(OFF_NEW_KEY_LO, nw[31:0]);
        wr(OFF_NEW_KEY_HI, nw[63:32]);
        c = '0;
        c.cls = CLS_REGISTER;
        c.host = h;
        c.nsid = ns;
        c.register_action_field = act;
        c.ignore_existing_key_bit = iek;
        c.ptpl_chg = pt;
        cmd(c, exp);
    endtask

    function automatic logic [15:0] nsv(input logic [3:0] m, input nrc_rtype_e rt,
                                        input logic [1:0] hd, input logic p);
        return {3'h0, p, 2'h0, hd, 1'b0, rt, m};
    endfunction
    task automatic ns_chk(input logic ns, input logic [15:0] e);
        logic [31:0] q;
        rd(OFF_NS_STATE, q);
        chk_word({16'h0000, ns ? q[31:16] : q[15:0]}, {16'h0000, e}, "namespace state");
    endtask

    // Expected access outcome for a non-holder, from reservation type and registrant status.
    function automatic logic expc(input nrc_rtype_e rt, input nrc_class_e c, input logic r);
        logic ex;
        logic pl;
        ex = (rt == RT_EA) || (rt == RT_EA_RO) || (rt == RT_EA_AR);
        pl = (rt == RT_WE) || (rt == RT_EA);
        case (c)
            CLS_READ: return ex && (!r || pl);
            CLS_WRITE: return !r || pl;
            CLS_ACQUIRE: return !(r && (rt == RT_WE_AR || rt == RT_EA_AR)); // Holders.
            CLS_RELPRE: return !r;
            default: return 1'b0;
        endcase
    endfunction

    task automatic t_register();
        logic [31:0] q;
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, q);
        chk_word(q, 32'h00000000, "unmapped read");
        chk_bit(hresp, 1'b0, "response code");
        reg_op(2'h0, 1'b0, ACT_REGISTER, 1'b0, PTPL_KEEP, 64'h0, K1, 1'b0);
        reg_op(2'h0, 1'b0, ACT_REGISTER, 1'b0, PTPL_KEEP, K2, K1, 1'b0);
        reg_op(2'h0, 1'b0, ACT_REGISTER, 1'b0, PTPL_KEEP, 64'h0, K2, 1'b1);
        reg_op(2'h0, 1'b0, 3'h1, 1'b0, PTPL_KEEP, K1, K2, 1'b0);
        rd(OFF_STATUS, q);
        chk_word(q, 32'h00000005, "invalid action status");
        reg_op(2'h1, 1'b0, ACT_REGISTER, 1'b0, PTPL_KEEP, 64'h0, K1, 1'b0);
        ns_chk(1'b0, nsv(4'h3, RT_NONE, 2'h0, 1'b0));
    endtask

    task automatic t_replace();
        op(CLS_RESVLOAD, 2'h0, 1'b0, RT_WE, 2'h3, 1'b0);
        reg_op(2'h0, 1'b0, ACT_REPLACE, 1'b0, PTPL_KEEP, K2, K3, 1'b1);
        reg_op(2'h0, 1'b0, ACT_REPLACE, 1'b0, PTPL_KEEP, K1, K3, 1'b0);
        reg_op(2'h0, 1'b0, ACT_REGISTER, 1'b0, PTPL_KEEP, 64'h0, K3, 1'b0);
        reg_op(2'h2, 1'b0, ACT_REPLACE, 1'b1, PTPL_KEEP, K2, K1, 1'b0);
        ns_chk(1'b0, nsv(4'h7, RT_WE, 2'h3, 1'b0));
    endtask

    // Host 0 registers on namespace 1, host 1 holds, host 2 stays a non-registrant there.
    task automatic t_matrix();
        nrc_class_e cl[5];
        nrc_rtype_e rt;
        cl = '{CLS_OTHER, CLS_READ, CLS_WRITE, CLS_ACQUIRE, CLS_RELPRE};
        reg_op(2'h0, 1'b1, ACT_REGISTER, 1'b0, PTPL_KEEP, 64'h0, K1, 1'b0);
        for (int t = 1; t <= 6; t++) begin
            rt = nrc_rtype_e'(t);
            op(CLS_RESVLOAD, 2'h0, 1'b1, rt, 2'h1, 1'b0);
            ns_chk(1'b1, nsv(4'h1, rt, 2'h1, 1'b0));
            for (int k = 0; k < 5; k++) begin
                op(cl[k], 2'h2, 1'b1, RT_NONE, 2'h0, expc(rt, cl[k], 1'b0));
                op(cl[k], 2'h0, 1'b1, RT_NONE, 2'h0, expc(rt, cl[k], 1'b1));
            end
            if (t <= 4) begin
                op(CLS_READ, 2'h1, 1'b1, RT_NONE, 2'h0, 1'b0);
                op(CLS_WRITE, 2'h1, 1'b1, RT_NONE, 2'h0, 1'b0);
            end
        end
    endtask

    // Pin events are held for four cycles and then left low long enough to settle.
    task automatic pulse(input logic pwr);
        @(posedge hclk);
        if (pwr) power_loss_pin <= 1'b1;
        else ctrl_reset_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        power_loss_pin <= 1'b0;
        ctrl_reset_pin <= 1'b0;
        repeat (5) @(posedge hclk);
    endtask

    task automatic t_persist();
        logic [31:0] q;
        reg_op(2'h0, 1'b0, ACT_REGISTER, 1'b0, PTPL_SET, 64'h0, K3, 1'b0);
        reg_op(2'h0, 1'b1, ACT_REGISTER, 1'b0, PTPL_SET, 64'h0, K1, 1'b0);
        ns_chk(1'b1, nsv(4'h1, RT_EA_AR, 2'h1, 1'b1));
        op(CLS_SETPTPL, 2'h0, 1'b1, RT_NONE, 2'h0, 1'b0);
        ns_chk(1'b1, nsv(4'h1, RT_EA_AR, 2'h1, 1'b0));
        op(CLS_ACQUIRE, 2'h2, 1'b1, RT_NONE, 2'h0, 1'b1);
        rd(OFF_STATUS, q);
        chk_word(q, 32'h00000003, "status after conflict");
        pulse(1'b0);
        rd(OFF_STATUS, q);
        chk_word(q, 32'h00000000, "status after reset");
        ns_chk(1'b0, nsv(4'h7, RT_WE, 2'h3, 1'b1));
        ns_chk(1'b1, nsv(4'h1, RT_EA_AR, 2'h1, 1'b0));
        pulse(1'b1);
        ns_chk(1'b0, nsv(4'h7, RT_WE, 2'h3, 1'b1));
        rd(OFF_NS_STATE, q);
        chk_word({25'h0, q[22:16]}, 32'h00000000, "lost on power loss");
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        hresetn = 1'b0;
        ctrl_reset_pin = 1'b0;
        power_loss_pin = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_register();
        t_replace();
        t_matrix();
        t_persist();
        give_verdict();
    end

    // The scenarios need about six hundred cycles; this bound of 20000 cycles only cuts a hang short.
    initial begin
        #(100 * 20000);
        failures++;
        give_verdict();
    end
endmodule

/* File: verilog/nrc_checker.sv */
`timescale 1ns/1ps
module nrc_checker
    import nrc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ctrl_reset_pin,
    input wire logic power_loss_pin,
    output logic cmd_done,
    output logic cmd_conflict
);

    // Bus address-phase capture.
    logic wr_pend_reg;
    logic [7:0] addr_reg;

    // Command path state.
    nrc_state_e state_reg;
    nrc_cmd_s cmd_reg;
    logic [NRC_KEY_W-1:0] cur_key_reg;
    logic [NRC_KEY_W-1:0] new_key_reg;
    nrc_status_s status_reg;

    // Namespace tables: keys indexed by namespace and host identifier.
    nrc_ns_s ns_reg [NRC_NS];
    logic [NRC_KEY_W-1:0] key_reg [NRC_NS][NRC_HOSTS];

    // Pin synchronisers and event edges.
    logic [1:0] crst_sync_reg;
    logic [1:0] pl_sync_reg;
    logic crst_last_reg;
    logic pl_last_reg;
    logic crst_evt;
    logic pl_evt;

    // Decision signals.
    logic exec;
    logic cmd_wr;
    nrc_ns_s st;
    logic is_reg;
    logic active;
    logic all_reg;
    logic is_holder;
    logic key_same;
    logic cur_ok;
    logic conflict_next;
    logic invalid_next;
    logic key_write;
    logic reg_set;
    logic resv_load;
    logic ptpl_write;
    logic ptpl_val;

    // Both pins come from outside the clock domain; only the second stage is read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crst_sync_reg <= 2'h0;
            pl_sync_reg <= 2'h0;
            crst_last_reg <= 1'b0;
            pl_last_reg <= 1'b0;
        end else begin
            crst_sync_reg <= {crst_sync_reg[0], ctrl_reset_pin};
            pl_sync_reg <= {pl_sync_reg[0], power_loss_pin};
            crst_last_reg <= crst_sync_reg[1];
            pl_last_reg <= pl_sync_reg[1];
        end
    end

    assign crst_evt = crst_sync_reg[1] && !crst_last_reg;
    assign pl_evt = pl_sync_reg[1] && !pl_last_reg;

    // A reset event cancels a command still in flight so it never half-applies.
    assign exec = (state_reg == ST_EXEC) && !crst_evt && !pl_evt;
    assign cmd_wr = wr_pend_reg && (addr_reg == OFF_CMD);

    // Bus slave: zero wait states, always OKAY, registered outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    // Read data is fetched at the address phase so it stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                OFF_CMD: hrdata <= cmd_reg;
                OFF_CUR_KEY_LO: hrdata <= cur_key_reg[31:0];
                OFF_CUR_KEY_HI: hrdata <= cur_key_reg[63:32];
                OFF_NEW_KEY_LO: hrdata <= new_key_reg[31:0];
                OFF_NEW_KEY_HI: hrdata <= new_key_reg[63:32];
                OFF_STATUS: hrdata <= status_reg;
                OFF_NS_STATE: hrdata <= {ns_reg[1], ns_reg[0]};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    // Key operand registers written by software.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_key_reg <= 64'h0;
            new_key_reg <= 64'h0;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                OFF_CUR_KEY_LO: cur_key_reg[31:0] <= hwdata;
                OFF_CUR_KEY_HI: cur_key_reg[63:32] <= hwdata;
                OFF_NEW_KEY_LO: new_key_reg[31:0] <= hwdata;
                OFF_NEW_KEY_HI: new_key_reg[63:32] <= hwdata;
                default: ;
            endcase
        end
    end

    // Writing the command word launches one check on the following cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            cmd_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: if (cmd_wr) begin
                    state_reg <= ST_EXEC;
                end
                ST_EXEC: if (!cmd_wr) begin
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (crst_evt || pl_evt) begin
                state_reg <= ST_IDLE;
            end
            if (cmd_wr) begin
                cmd_reg <= hwdata;
            end
        end
    end

    // Access decision for the command under check.
    always_comb begin
        st = ns_reg[cmd_reg.nsid];
        is_reg = st.regmask[cmd_reg.host];
        active = st.rtype != RT_NONE;
        all_reg = (st.rtype == RT_WE_AR) || (st.rtype == RT_EA_AR);
        // Every registrant holds an all-registrants reservation; others have one holder.
        is_holder = active && (all_reg ? is_reg : (st.holder == cmd_reg.host));
        key_same = key_reg[cmd_reg.nsid][cmd_reg.host] == new_key_reg;
        cur_ok = key_reg[cmd_reg.nsid][cmd_reg.host] == cur_key_reg;
        conflict_next = 1'b0;
        invalid_next = 1'b0;
        key_write = 1'b0;
        reg_set = 1'b0;
        resv_load = 1'b0;
        ptpl_write = 1'b0;
        ptpl_val = st.power_loss_persist_state;
        case (cmd_reg.cls)
            CLS_REGISTER: begin
                // Only the issuing host's entry is compared, never other hosts' keys.
                if (cmd_reg.register_action_field == ACT_REGISTER) begin
                    conflict_next = is_reg && !key_same;
                    key_write = !conflict_next;
                end else if (cmd_reg.register_action_field == ACT_REPLACE) begin
                    if (cmd_reg.ignore_existing_key_bit) begin
                        key_write = 1'b1;
                    end else begin
                        conflict_next = !is_reg || !cur_ok;
                        key_write = !conflict_next;
                    end
                end else begin
                    invalid_next = 1'b1;
                end
                reg_set = key_write;
                if (key_write && cmd_reg.ptpl_chg == PTPL_SET) begin
                    ptpl_write = 1'b1;
                    ptpl_val = 1'b1;
                end else if (key_write && cmd_reg.ptpl_chg == PTPL_CLR) begin
                    ptpl_write = 1'b1;
                    ptpl_val = 1'b0;
                end else if (cmd_reg.ptpl_chg != PTPL_KEEP && key_write) begin
                    invalid_next = 1'b1;
                end
            end
            CLS_READ: begin
                // Write-exclusive types never block reads by anyone.
                conflict_next = active && !is_holder && ((st.rtype == RT_EA) ||
                    (((st.rtype == RT_EA_RO) || (st.rtype == RT_EA_AR)) && !is_reg));
            end
            CLS_WRITE: begin
                conflict_next = active && !is_holder && ((st.rtype == RT_WE) ||
                    (st.rtype == RT_EA) || !is_reg);
            end
            CLS_ACQUIRE: conflict_next = active && !is_holder;
            CLS_RELPRE: conflict_next = active && !is_holder && !is_reg;
            CLS_SETPTPL: begin
                ptpl_write = 1'b1;
                ptpl_val = cmd_reg.ptpl_chg == PTPL_SET;
            end
            CLS_RESVLOAD: resv_load = 1'b1;
            default: conflict_next = 1'b0;
        endcase
    end

    // Result status; a completion in the cycle of a new launch still reads as done.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= '0;
            cmd_done <= 1'b0;
            cmd_conflict <= 1'b0;
        end else begin
            cmd_done <= exec;
            cmd_conflict <= exec && conflict_next;
            if (exec) begin
                status_reg.done <= 1'b1;
                status_reg.conflict <= conflict_next;
                status_reg.invalid <= invalid_next;
            end else if (cmd_wr || crst_evt) begin
                status_reg <= '0;
            end
        end
    end

    // Per-namespace tables; a controller reset does not touch them.
    for (genvar n = 0; n < NRC_NS; n++) begin : g_ns
        logic sel;
        assign sel = exec && (cmd_reg.nsid == 1'(n));

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ns_reg[n] <= '0;
            end else if (pl_evt && !ns_reg[n].power_loss_persist_state) begin
                ns_reg[n].regmask <= 4'h0;
                ns_reg[n].rtype <= RT_NONE;
                ns_reg[n].holder <= 2'h0;
            end else if (sel) begin
                // Key replacement never writes the type or holder fields.
                if (reg_set) begin
                    ns_reg[n].regmask[cmd_reg.host] <= 1'b1;
                end
                if (ptpl_write) begin
                    ns_reg[n].power_loss_persist_state <= ptpl_val;
                end
                if (resv_load) begin
                    ns_reg[n].rtype <= cmd_reg.rtype;
                    ns_reg[n].holder <= cmd_reg.holder;
                end
            end
        end

        for (genvar h = 0; h < NRC_HOSTS; h++) begin : g_host
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    key_reg[n][h] <= 64'h0;
                end else if (sel && key_write && cmd_reg.host == 2'(h)) begin
                    key_reg[n][h] <= new_key_reg;
                end
            end
        end
    end

    // Every launched command not cancelled by a reset event completes with a pulse one cycle later.
    exec_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec |=> cmd_done && status_reg.done && cmd_conflict == status_reg.conflict)
        else $error("command did not complete after check");

    reg_diff_key_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_REGISTER && cmd_reg.register_action_field == ACT_REGISTER
        && is_reg && !key_same |=> cmd_conflict)
        else $error("registration with a different key was accepted");

    reg_same_key_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_REGISTER && cmd_reg.register_action_field == ACT_REGISTER
        && key_same |=> !cmd_conflict && key_reg[$past(cmd_reg.nsid)][$past(cmd_reg.host)]
        == $past(new_key_reg))
        else $error("repeat registration with the same key was refused");

    replace_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_REGISTER && !pl_evt |=>
        ns_reg[$past(cmd_reg.nsid)].rtype == $past(st.rtype) &&
        ns_reg[$past(cmd_reg.nsid)].holder == $past(st.holder))
        else $error("key replacement disturbed the reservation");

    read_ea_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_READ && st.rtype == RT_EA &&
        st.holder != cmd_reg.host |=> cmd_conflict)
        else $error("read by non-holder passed plain exclusive access");

    write_we_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_WRITE && (st.rtype == RT_WE_RO || st.rtype == RT_EA_RO)
        && is_reg |=> !cmd_conflict)
        else $error("write by registrant refused under registrants-only type");

    acquire_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_ACQUIRE && active && !is_holder |=> cmd_conflict)
        else $error("acquire by non-holder was allowed");

    relpre_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_RELPRE && !is_reg && !is_holder |=>
        cmd_conflict == $past(active))
        else $error("release by non-registrant handled wrongly");

    other_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_OTHER |=> cmd_done && !cmd_conflict)
        else $error("unrelated command was refused");

    ctrl_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        crst_evt && !pl_evt |=> $stable(ns_reg[0]) && $stable(ns_reg[1]))
        else $error("controller reset changed the namespace table");

    persist_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pl_evt && ns_reg[0].power_loss_persist_state |=> $stable(ns_reg[0].rtype))
        else $error("persistent reservation lost at power loss");

    loss_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pl_evt && !ns_reg[1].power_loss_persist_state |=> ns_reg[1].regmask == 4'h0 &&
        ns_reg[1].rtype == RT_NONE)
        else $error("power loss kept a non-persistent namespace");

    // Reads stay open to everyone under every write-exclusive flavour.
    read_we_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_READ && (st.rtype == RT_WE || st.rtype == RT_WE_RO ||
        st.rtype == RT_WE_AR) |=> !cmd_conflict)
        else $error("read refused under a write-exclusive type");

    write_plain_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_WRITE && (st.rtype == RT_WE || st.rtype == RT_EA) &&
        !is_holder |=> cmd_conflict)
        else $error("write by non-holder passed a plain type");

    // The ignore bit must install the key even for a host with no entry yet.
    replace_iek_a: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd_reg.cls == CLS_REGISTER && cmd_reg.register_action_field == ACT_REPLACE
        && cmd_reg.ignore_existing_key_bit |=> !cmd_conflict &&
        key_reg[$past(cmd_reg.nsid)][$past(cmd_reg.host)] == $past(new_key_reg))
        else $error("replace with ignore bit did not install the key");

endmodule

/* File: verilog/nrc_pkg.sv */
package nrc_pkg;

    // Table sizes: namespaces with reservation support and hosts per subsystem.
    localparam int NRC_NS = 2;
    localparam int NRC_HOSTS = 4;
    localparam int NRC_KEY_W = 64;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CUR_KEY_LO = 8'h04;
    localparam logic [7:0] OFF_CUR_KEY_HI = 8'h08;
    localparam logic [7:0] OFF_NEW_KEY_LO = 8'h0C;
    localparam logic [7:0] OFF_NEW_KEY_HI = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_NS_STATE = 8'h18;

    // Command classes that the checker sorts incoming commands into.
    typedef enum logic [2:0] {
        CLS_OTHER = 3'h0,
        CLS_REGISTER = 3'h1,
        CLS_READ = 3'h2,
        CLS_WRITE = 3'h3,
        CLS_ACQUIRE = 3'h4,
        CLS_RELPRE = 3'h5,
        CLS_SETPTPL = 3'h6,
        CLS_RESVLOAD = 3'h7
    } nrc_class_e;

    // Reservation types; zero means no reservation is held.
    typedef enum logic [2:0] {
        RT_NONE = 3'h0,
        RT_WE = 3'h1,
        RT_EA = 3'h2,
        RT_WE_RO = 3'h3,
        RT_EA_RO = 3'h4,
        RT_WE_AR = 3'h5,
        RT_EA_AR = 3'h6
    } nrc_rtype_e;

    // Register action field codes.
    localparam logic [2:0] ACT_REGISTER = 3'h0;
    localparam logic [2:0] ACT_REPLACE = 3'h2;

    // Power-loss persistence change codes carried by register commands.
    localparam logic [1:0] PTPL_KEEP = 2'h0;
    localparam logic [1:0] PTPL_CLR = 2'h2;
    localparam logic [1:0] PTPL_SET = 2'h3;

    // Layout of the command word.
    typedef struct packed {
        logic [5:0] rsv3;
        logic [1:0] holder;
        logic rsv2;
        nrc_rtype_e rtype;
        logic [1:0] rsv1b;
        logic [1:0] ptpl_chg;
        logic ignore_existing_key_bit;
        logic [2:0] register_action_field;
        logic [2:0] rsv1;
        logic nsid;
        logic [1:0] rsv0a;
        logic [1:0] host;
        logic rsv0;
        nrc_class_e cls;
    } nrc_cmd_s;

    // Per-namespace state, also its readback layout.
    typedef struct packed {
        logic [2:0] rsv2;
        logic power_loss_persist_state;
        logic [1:0] rsv1;
        logic [1:0] holder;
        logic rsv0;
        nrc_rtype_e rtype;
        logic [3:0] regmask;
    } nrc_ns_s;

    // Status register layout.
    typedef struct packed {
        logic [28:0] rsv;
        logic invalid;
        logic conflict;
        logic done;
    } nrc_status_s;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } nrc_state_e;

endpackage
